// >>> pei_pkg.sv
// constants for the phy event interrupt logic
// assumes an axi4-lite master on the same clock as the block
//
// Contract
// - level select bit 3, reset 1: high idles high, asserts low.
// - test bit 2 forces interrupt until software clears it.
// - master enable bit 1 gates event interrupts, each also per-event.
// - bit 0 selects pin role: interrupt output or power-down input.
// - event interrupt reaches pin only with control bits 1 and 0 set.
// - status bit set when event happened since last event register read.
// - status bits set even when their enables are clear.
// - event with its enable set generates an interrupt.
// - bit 13 link change pending, read-only, clears on read.
// - bit 12 speed change pending, read-only, clears on read.
// - bit 11 duplex change pending, read-only, clears on read.
// - bit 10 auto-negotiation complete pending, clears on read.
// - bit 9 false-carrier counter above half full, clears on read.
// - bit 8 receive-error counter above half full, clears on read.
// - enable bits 5..0, reset 0, gate the six events in order.
// - event register bits 15:14 and 7:6 ignore writes, read zero.
package pei_pkg;
  localparam int NUM_EVENTS = 6;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h11;
  localparam logic [7:0] IDX_EVENTS  = 8'h12;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h21;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h22;
  localparam logic [9:0] ADDR_CONTROL    = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_EVENTS     = {IDX_EVENTS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_CLEAR  = {IDX_IRQ_CLEAR, 2'b00};
  localparam logic [9:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};
  // control field positions
  localparam int CTL_OE_BIT   = 0;
  localparam int CTL_EN_BIT   = 1;
  localparam int CTL_TEST_BIT = 2;
  localparam int CTL_POL_BIT  = 3;
  localparam logic [3:0] CTL_RESET = 4'h8;
  // event register layout: status at 13:8, enables at 5:0
  localparam int EVT_STATUS_LSB = 8;
  localparam logic [5:0] EVT_EN_RESET = 6'h00;
  // half-full thresholds of the counters
  localparam logic [7:0]  FC_HALF = 8'h7F;
  localparam logic [15:0] RE_HALF = 16'h7FFF;
  // block-level sticky events: 0 access error, 1 pin interrupt asserted
  localparam int NUM_SYS_IRQ = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> pei_sync.sv
// two-flop synchroniser for one level
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module pei_sync #(
  // level held in reset: the idle level of the input
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // data
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// >>> pei_change_det.sv
// synchronised level with change and rising-edge pulses
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module pei_change_det (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in, pulses out
  input  wire logic d,
  output logic      changed,
  output logic      rose
);
  logic       sync_q;
  logic       last_reg;
  logic [2:0] primed_reg;
  pei_sync u_sync (
    .clk (clk),
    .rst (rst),
    .d   (d),
    .q   (sync_q)
  );
  // primed waits until both the sync output and its copy are real,
  // so a level that sits high through reset raises no false change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_reg   <= 1'b0;
      primed_reg <= 3'h0;
    end else begin
      last_reg   <= sync_q;
      primed_reg <= {primed_reg[1:0], 1'b1};
    end
  end
  assign changed = primed_reg[2] && (sync_q != last_reg);
  assign rose    = primed_reg[2] && sync_q && !last_reg;
endmodule

// >>> pei_top.sv
// phy event interrupt logic with axi4-lite register access
// assumes phy status levels and counters arrive asynchronously
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module pei_top (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // axi4-lite write address
  input  wire logic [9:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // axi4-lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // axi4-lite read address
  input  wire logic [9:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // axi4-lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // phy status levels
  input  wire logic        LINK_UP,
  input  wire logic        SPEED_100,
  input  wire logic        FULL_DUPLEX,
  input  wire logic        AUTONEG_DONE,
  input  wire logic [7:0]  FALSE_CARRIER_COUNT,
  input  wire logic [15:0] RX_ERROR_COUNT,
  // shared interrupt / power-down pin
  input  wire logic        IRQ_OR_POWERDOWN_PIN_LEVEL,
  output logic             IRQ_OR_POWERDOWN_PIN_DRIVE,
  output logic             IRQ_OR_POWERDOWN_PIN_OE,
  output logic             POWERDOWN_REQ,
  // system interrupt
  output logic             SYS_IRQ
);
  logic [3:0]  ctl_reg;
  logic [5:0]  evt_en_reg;
  logic [5:0]  evt_stat_reg;
  logic [1:0]  sys_stat_reg;
  logic [1:0]  sys_en_reg;
  logic [5:0]  evt_pulse;
  logic        fc_half_s;
  logic        re_half_s;
  logic        pin_s;
  logic        irq_active;
  logic        irq_active_last_reg;

  // write channel state
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [9:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic        wr_hit;
  logic        ar_fire;
  logic        rd_events;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_ctl;
  logic        wr_evt;
  logic        wr_sys_clr;
  logic        wr_sys_en;
  logic [1:0]  sys_clr;
  logic [1:0]  sys_set;
  logic        irq_rise;
  logic        bad_access;

  // link, speed, duplex changes and negotiation completion
  pei_change_det u_link (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .d       (LINK_UP),
    .changed (evt_pulse[5]),
    .rose    ()
  );
  pei_change_det u_speed (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .d       (SPEED_100),
    .changed (evt_pulse[4]),
    .rose    ()
  );
  pei_change_det u_duplex (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .d       (FULL_DUPLEX),
    .changed (evt_pulse[3]),
    .rose    ()
  );
  pei_change_det u_aneg (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .d       (AUTONEG_DONE),
    .changed (),
    .rose    (evt_pulse[2])
  );
  // counters compared before sync: each result is a single slow level
  pei_change_det u_fc_half (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .d       (fc_half_s),
    .changed (),
    .rose    (evt_pulse[1])
  );
  pei_change_det u_re_half (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .d       (re_half_s),
    .changed (),
    .rose    (evt_pulse[0])
  );
  assign fc_half_s = FALSE_CARRIER_COUNT > pei_pkg::FC_HALF;
  assign re_half_s = RX_ERROR_COUNT > pei_pkg::RE_HALF;

  // the wire idles high: reset there, so no power-down follows reset
  pei_sync #(
    .RST_VAL (1'b1)
  ) u_pin_sync (
    .clk (CLOCK),
    .rst (SYS_RST),
    .d   (IRQ_OR_POWERDOWN_PIN_LEVEL),
    .q   (pin_s)
  );

  // axi handshakes
  assign wr_fire = aw_held_reg && w_held_reg && !BVALID;
  assign ar_fire = ARVALID && ARREADY;
  assign wr_hit  = awaddr_reg == pei_pkg::ADDR_CONTROL
                || awaddr_reg == pei_pkg::ADDR_EVENTS
                || awaddr_reg == pei_pkg::ADDR_IRQ_STATUS
                || awaddr_reg == pei_pkg::ADDR_IRQ_CLEAR
                || awaddr_reg == pei_pkg::ADDR_IRQ_ENABLE;
  assign rd_events = ar_fire && ARADDR == pei_pkg::ADDR_EVENTS;

  // register strobes: lane 0 carries every implemented bit
  assign wr_ctl     = wr_fire && wstrb_reg[0]
                   && awaddr_reg == pei_pkg::ADDR_CONTROL;
  assign wr_evt     = wr_fire && wstrb_reg[0]
                   && awaddr_reg == pei_pkg::ADDR_EVENTS;
  assign wr_sys_clr = wr_fire && wstrb_reg[0]
                   && awaddr_reg == pei_pkg::ADDR_IRQ_CLEAR;
  assign wr_sys_en  = wr_fire && wstrb_reg[0]
                   && awaddr_reg == pei_pkg::ADDR_IRQ_ENABLE;

  // write address: one held until its response is taken
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 10'h000;
      AWREADY     <= 1'b0;
    end else begin
      AWREADY <= !aw_held_reg && !(AWVALID && AWREADY);
      if (AWVALID && AWREADY) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= AWADDR;
        AWREADY     <= 1'b0;
      end else if (BVALID && BREADY) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  // write data: mirrors the address side, either may come first
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
      WREADY     <= 1'b0;
    end else begin
      WREADY <= !w_held_reg && !(WVALID && WREADY);
      if (WVALID && WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= WDATA;
        wstrb_reg  <= WSTRB;
        WREADY     <= 1'b0;
      end else if (BVALID && BREADY) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // response once both halves are held; stands until taken
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BVALID <= 1'b0;
      BRESP  <= 2'h0;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP  <= wr_hit ? pei_pkg::RESP_OKAY : pei_pkg::RESP_SLVERR;
    end else if (BVALID && BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // control register, low byte lane only
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_reg <= pei_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl_reg <= wdata_reg[3:0];
    end
  end

  // event enables; status half is read-only, reserved ignored
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      evt_en_reg <= pei_pkg::EVT_EN_RESET;
    end else if (wr_evt) begin
      evt_en_reg <= wdata_reg[5:0];
    end
  end

  // sticky status: an event in the read cycle survives the clear
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      evt_stat_reg <= 6'h00;
    end else begin
      evt_stat_reg <= (rd_events ? 6'h00 : evt_stat_reg) | evt_pulse;
    end
  end

  // pin level: events need master enable and output role
  always_comb begin
    irq_active = ctl_reg[pei_pkg::CTL_TEST_BIT]
      || (ctl_reg[pei_pkg::CTL_EN_BIT]
          && ctl_reg[pei_pkg::CTL_OE_BIT]
          && |(evt_stat_reg & evt_en_reg));
  end

  // level follows the pending state, idle again after the read unless the test bit is set
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ_OR_POWERDOWN_PIN_DRIVE <= 1'b1;
    end else begin
      IRQ_OR_POWERDOWN_PIN_DRIVE <= irq_active
        ^ ctl_reg[pei_pkg::CTL_POL_BIT];
    end
  end

  // output role follows bit 0, even while the test bit forces
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      IRQ_OR_POWERDOWN_PIN_OE <= 1'b0;
    end else begin
      IRQ_OR_POWERDOWN_PIN_OE <= ctl_reg[pei_pkg::CTL_OE_BIT];
    end
  end

  // power-down input is active low and heard only in input role
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      POWERDOWN_REQ <= 1'b0;
    end else begin
      POWERDOWN_REQ <= !ctl_reg[pei_pkg::CTL_OE_BIT] && !pin_s;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_active_last_reg <= 1'b0;
    end else begin
      irq_active_last_reg <= irq_active;
    end
  end

  // block-level events: bad access and the pin's assertion edge
  assign irq_rise   = irq_active && !irq_active_last_reg;
  assign bad_access = (wr_fire && !wr_hit) || (ar_fire && !rd_hit);

  always_comb begin
    sys_set = {irq_rise, bad_access};
    sys_clr = 2'h0;
    if (wr_sys_clr) begin
      sys_clr = wdata_reg[1:0];
    end
  end

  // an event in the clearing cycle survives: set wins
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sys_stat_reg <= 2'h0;
    end else begin
      sys_stat_reg <= (sys_stat_reg & ~sys_clr) | sys_set;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sys_en_reg <= 2'h0;
    end else if (wr_sys_en) begin
      sys_en_reg <= wdata_reg[1:0];
    end
  end

  // registered, so one cycle behind the status it reports
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SYS_IRQ <= 1'b0;
    end else begin
      SYS_IRQ <= |(sys_stat_reg & sys_en_reg);
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (ARADDR)
      pei_pkg::ADDR_CONTROL:    rd_word[3:0] = ctl_reg;
      pei_pkg::ADDR_EVENTS: begin
        rd_word[pei_pkg::EVT_STATUS_LSB +: pei_pkg::NUM_EVENTS]
          = evt_stat_reg;
        rd_word[5:0]  = evt_en_reg;
      end
      pei_pkg::ADDR_IRQ_STATUS: rd_word[1:0] = sys_stat_reg;
      pei_pkg::ADDR_IRQ_CLEAR:  rd_word = 32'h00000000;
      pei_pkg::ADDR_IRQ_ENABLE: rd_word[1:0] = sys_en_reg;
      default:                  rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= 2'h0;
    end else begin
      ARREADY <= !RVALID && !ar_fire;
      if (ar_fire) begin
        RVALID <= 1'b1;
        RDATA  <= rd_word;
        RRESP  <= rd_hit ? pei_pkg::RESP_OKAY : pei_pkg::RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end
endmodule

// >>> pei_checker.sv
// bus and pin assertions for pei_top
// assumes one clock domain, async active-high reset
`timescale 1ns/1ps
module pei_checker (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  // register bus
  input wire logic        AWREADY,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [9:0]  ARADDR,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // shared pin
  input wire logic        IRQ_OR_POWERDOWN_PIN_OE,
  input wire logic        POWERDOWN_REQ
);
  logic [9:0] ar_reg;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // read data is judged by the address taken
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) ar_reg <= 10'h000;
    else if (ARVALID && ARREADY) ar_reg <= ARADDR;
  end
  a_b_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_r_follows: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_ar_blocked: assert property (RVALID |-> !ARREADY)
    else $error("read taken while busy");
  a_wr_blocked: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while busy");
  a_evt_rsvd: assert property (
    RVALID && ar_reg == pei_pkg::ADDR_EVENTS
    |-> RDATA[31:14] == 18'h0 && RDATA[7:6] == 2'h0)
    else $error("event reserved bits set");
  a_ctl_rsvd: assert property (
    RVALID && ar_reg == pei_pkg::ADDR_CONTROL |-> RDATA[31:4] == 28'h0)
    else $error("control reserved bits set");
  a_pd_role: assert property (
    POWERDOWN_REQ |-> !IRQ_OR_POWERDOWN_PIN_OE)
    else $error("power-down while pin drives");
endmodule
bind pei_top pei_checker chk_u (
  .CLOCK, .SYS_RST, .AWREADY, .WREADY, .BRESP, .BVALID, .BREADY,
  .ARADDR, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY,
  .IRQ_OR_POWERDOWN_PIN_OE, .POWERDOWN_REQ
);

// >>> pei_host_model.sv
// host side of the shared interrupt / power-down pin
// assumes a pull-up on the wire
`timescale 1ns/1ps
module pei_host_model (
  // device side
  input  wire logic pin_drive,
  input  wire logic pin_oe,
  // host command
  input  wire logic hold_low,
  // resolved wire
  output logic      pin_level
);
  // host may pull low only while the device has released it
  assign pin_level = pin_oe ? pin_drive : !hold_low;
endmodule

// >>> tb_top.sv
// self-checking bench for pei_top
// assumes pei_checker is bound in by its own file
`timescale 1ns/1ps
module tb_top;
  localparam logic [9:0] CTL = pei_pkg::ADDR_CONTROL;
  localparam logic [9:0] EVT = pei_pkg::ADDR_EVENTS;
  localparam logic [9:0] SST = pei_pkg::ADDR_IRQ_STATUS;
  localparam logic [9:0] SCL = pei_pkg::ADDR_IRQ_CLEAR;
  localparam logic [9:0] SEN = pei_pkg::ADDR_IRQ_ENABLE;
  logic        CLOCK = 1'b0, SYS_RST = 1'b1;
  logic [9:0]  AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0;
  logic [3:0]  WSTRB = 4'hF;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic        ARVALID = 1'b0, RREADY = 1'b0;
  logic        LINK_UP = 1'b0, SPEED_100 = 1'b0;
  logic        FULL_DUPLEX = 1'b0, AUTONEG_DONE = 1'b0;
  logic [7:0]  FALSE_CARRIER_COUNT = '0;
  logic [15:0] RX_ERROR_COUNT = '0;
  logic        hold_low = 1'b0, probe = 1'b0;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, SYS_IRQ;
  wire         POWERDOWN_REQ, IRQ_OR_POWERDOWN_PIN_LEVEL;
  wire         IRQ_OR_POWERDOWN_PIN_DRIVE, IRQ_OR_POWERDOWN_PIN_OE;
  wire [1:0]   BRESP, RRESP;
  wire [31:0]  RDATA;
  logic [33:0] exp_q[$];
  int          fails = 0, check_count = 0, cyc = 0;
  always #50 CLOCK = ~CLOCK;
  pei_top dut_u (.CLOCK, .SYS_RST, .AWADDR, .AWVALID, .AWREADY, .WDATA,
    .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
    .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .LINK_UP, .SPEED_100,
    .FULL_DUPLEX, .AUTONEG_DONE, .FALSE_CARRIER_COUNT, .RX_ERROR_COUNT,
    .IRQ_OR_POWERDOWN_PIN_LEVEL, .IRQ_OR_POWERDOWN_PIN_DRIVE,
    .IRQ_OR_POWERDOWN_PIN_OE, .POWERDOWN_REQ, .SYS_IRQ);
  pei_host_model host_u (.pin_drive(IRQ_OR_POWERDOWN_PIN_DRIVE),
    .pin_oe(IRQ_OR_POWERDOWN_PIN_OE), .hold_low,
    .pin_level(IRQ_OR_POWERDOWN_PIN_LEVEL));
  task automatic wrap_up();
    // a note that no result ever matched is a miss as well
    if (exp_q.size() != 0) fails++;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] got);
    logic [33:0] e;
    e = exp_q.pop_front();
    check_count++;
    if (got !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, e);
    end
  endtask
  // results are matched in order against the notes of the driver
  always @(posedge CLOCK) begin
    if (BVALID && BREADY) cmp({BRESP, 32'h0});
    if (RVALID && RREADY) cmp({RRESP, RDATA});
    if (probe)
      cmp({31'h0, SYS_IRQ, POWERDOWN_REQ, IRQ_OR_POWERDOWN_PIN_LEVEL});
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    @(posedge CLOCK);
  endtask
  // expected bits: system irq, power-down request, pin level
  task automatic see(input logic [2:0] e);
    exp_q.push_back({31'h0, e});
    repeat (3) @(posedge CLOCK);
    probe <= 1'b1;
    @(posedge CLOCK);
    probe <= 1'b0;
    @(posedge CLOCK);
  endtask
  // i is the enable bit index; counters go below half first
  task automatic evt(input int i);
    case (i)
      5: LINK_UP <= !LINK_UP;
      4: SPEED_100 <= !SPEED_100;
      3: FULL_DUPLEX <= !FULL_DUPLEX;
      2: AUTONEG_DONE <= 1'b0;
      1: FALSE_CARRIER_COUNT <= 8'h7F & 8'($urandom);
      default: RX_ERROR_COUNT <= 16'h7FFF & 16'($urandom);
    endcase
    repeat (8) @(posedge CLOCK);
    if (i == 2) AUTONEG_DONE <= 1'b1;
    if (i == 1) FALSE_CARRIER_COUNT <= 8'h80 | 8'($urandom);
    if (i == 0) RX_ERROR_COUNT <= 16'h8000 | 16'($urandom);
    if (i < 3) repeat (8) @(posedge CLOCK);
  endtask
  initial begin
    void'($urandom(32'h2EB7548E));
    repeat (12) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    rd(CTL, 34'h8);
    rd(EVT, 34'h0);
    wr(SEN, 32'h0, 2'h0);
    see(3'h1);
    wr(EVT, 32'hFFFF, 2'h0);
    rd(EVT, 34'h3F);
    wr(EVT, 32'h0, 2'h0);
    // lane 0 off: the control write must not land
    WSTRB <= 4'hE;
    wr(CTL, 32'h7, 2'h0);
    WSTRB <= 4'hF;
    rd(CTL, 34'h8);
    wr(CTL, 32'hB, 2'h0);
    for (int i = 0; i < 6; i++) evt(i);
    see(3'h1);
    rd(EVT, 34'h3F00);
    rd(EVT, 34'h0);
    for (int i = 0; i < 6; i++) begin
      wr(EVT, 32'h1 << i, 2'h0);
      evt(i);
      see(3'h0);
      rd(EVT, 34'h101 << i);
      see(3'h1);
    end
    wr(EVT, 32'h3F, 2'h0);
    wr(CTL, 32'h9, 2'h0);
    evt(5);
    see(3'h1);
    wr(CTL, 32'hB, 2'h0);
    see(3'h0);
    wr(CTL, 32'h3, 2'h0);
    see(3'h1);
    rd(EVT, 34'h203F);
    see(3'h0);
    wr(CTL, 32'h7, 2'h0);
    rd(EVT, 34'h3F);
    see(3'h1);
    wr(CTL, 32'h8, 2'h0);
    hold_low <= 1'b1;
    see(3'h2);
    hold_low <= 1'b0;
    wr(SCL, 32'h3, 2'h0);
    wr(10'h3FC, 32'h1, 2'h2);
    rd(10'h3F8, 34'h200000000);
    rd(SST, 34'h1);
    wr(SEN, 32'h1, 2'h0);
    see(3'h5);
    wr(SCL, 32'h1, 2'h0);
    see(3'h1);
    wrap_up();
  end
endmodule
